// File: dv/irq_source_model.sv
// Model of the peripheral event sources and of the CPU core's vector logic.
// Assumes the bench asks for events by mask and for service by a level.
`timescale 1ns/10ps
module irq_source_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [4:0]  fire,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        serve,
  input  wire logic        wake_latch_strobe,
  input  wire logic [14:0] irq_request,
  output logic             symbol_event,
  output logic             converter_event,
  output logic             watchdog_warning,
  output logic             minute_tick,
  output logic             wake_event,
  output logic             copy_ack,
  output logic             vector_taken_a,
  output logic             vector_taken_b
);
  logic [4:0] ev;   // One-cycle event pulses
  logic [4:0] cnt;  // Cycles left before the copy answer

  assign {wake_event, minute_tick, watchdog_warning, converter_event, symbol_event} = ev;

  // Event pulses, delayed copy answer, one vector per pending port 3 request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= 5'h00;
      cnt <= 5'h00;
      copy_ack <= 1'b0;
      vector_taken_a <= 1'b0;
      vector_taken_b <= 1'b0;
    end else begin
      ev <= fire;
      copy_ack <= 1'b0;
      // Slow or prompt answer, chosen by the bench
      if (wake_latch_strobe) begin
        cnt <= {1'b0, ack_delay} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
        copy_ack <= (cnt == 5'h01);
      end
      // Core vectors only while service is allowed
      vector_taken_a <= serve & irq_request[0] & ~vector_taken_a;
      vector_taken_b <= serve & irq_request[2] & ~vector_taken_b;
    end
  end
endmodule

// File: dv/tb_interrupt_request_flags.sv
// Self-checking bench of the interrupt request flag block over APB.
// Assumes irq_pkg and irq_cfg.svh; the source model stands for the far side.
`timescale 1ns/10ps
`include "irq_cfg.svh"
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("ERROR %0t: value %0h, expected %0h", $time, (g), (e)); \
  end \
end
module tb_interrupt_request_flags
  import irq_pkg::*;
;
  logic        pclk = 1'b0;      // Bus clock
  logic        presetn, clk_en, psel, penable, pwrite, serve;
  logic [9:0]  paddr;            // Byte address
  logic [31:0] pwdata, prdata;   // Bus data
  logic        pready, pslverr;  // Bus answer
  logic [3:0]  port1_in, core_requests, ack_delay, en;
  logic [1:0]  port3_level, wake_mode;
  logic [4:0]  fire;             // Event request mask
  logic        symbol_event, converter_event, watchdog_warning, minute_tick, wake_event;
  logic        copy_ack, vector_taken_a, vector_taken_b, power_down_wake;
  logic        wakeup_vector_source, wake_latch_strobe, wake_load_strobe, wake_run;
  logic        wake_write_value, clock_latch_strobe, clock_load_strobe;
  logic        clock_writeback_disable;
  logic [14:0] irq_request, irq_priority;
  logic [7:0]  seconds_value, v, pol, lvl;
  logic [15:0] seed;             // Random source state
  int          fails = 0, checks_done = 0, n_wl = 0, n_wd = 0, n_cl = 0, n_cs = 0;
  logic [7:0]  reg_idx [10] = '{`TIMER_EXT_IDX, `WAKE_CTRL_IDX, `ENABLE_A_IDX, `PRIO_A_IDX,
    `REQ_FLAGS_IDX, `CLOCK_CTRL_IDX, `SECONDS_IDX, `ENABLE_B_IDX, `POLARITY_IDX, `PRIO_B_IDX};

  always #12.5 pclk = ~pclk;

  // Strobe cycle counters
  always @(posedge pclk) begin
    n_wl += int'(wake_latch_strobe === 1'b1);
    n_wd += int'(wake_load_strobe === 1'b1);
    n_cl += int'(clock_latch_strobe === 1'b1);
    n_cs += int'(clock_load_strobe === 1'b1);
  end

  interrupt_request_flags DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port1_in(port1_in), .symbol_event(symbol_event),
    .converter_event(converter_event), .watchdog_warning(watchdog_warning),
    .minute_tick(minute_tick), .wake_event(wake_event), .copy_ack(copy_ack),
    .port3_level(port3_level), .vector_taken_a(vector_taken_a),
    .vector_taken_b(vector_taken_b), .core_requests(core_requests),
    .irq_request(irq_request), .irq_priority(irq_priority),
    .power_down_wake(power_down_wake), .wakeup_vector_source(wakeup_vector_source),
    .wake_latch_strobe(wake_latch_strobe), .wake_load_strobe(wake_load_strobe),
    .wake_run(wake_run), .wake_mode(wake_mode), .wake_write_value(wake_write_value),
    .clock_latch_strobe(clock_latch_strobe), .clock_load_strobe(clock_load_strobe),
    .clock_writeback_disable(clock_writeback_disable), .seconds_value(seconds_value));

  irq_source_model src (.pclk(pclk), .presetn(presetn), .fire(fire), .ack_delay(ack_delay),
    .serve(serve), .wake_latch_strobe(wake_latch_strobe), .irq_request(irq_request),
    .symbol_event(symbol_event), .converter_event(converter_event),
    .watchdog_warning(watchdog_warning), .minute_tick(minute_tick), .wake_event(wake_event),
    .copy_ack(copy_ack), .vector_taken_a(vector_taken_a), .vector_taken_b(vector_taken_b));

  // Next random word
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected port 1 flags, placed at bits 0, 1, 2 and 4
  function logic [7:0] p1_exp(input logic [3:0] p, input logic [3:0] l, input logic [3:0] e);
    logic [3:0] f;
    f = e & ~(p ^ l);
    return {3'h0, f[3], 1'b0, f[2:0]};
  endfunction

  // One APB transfer, sometimes stalled by the clock enable
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
           output logic [7:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    seed = lfsr(seed);
    penable <= 1'b1;
    clk_en <= seed[0] | seed[1];
    @(posedge pclk);
    while (pready !== 1'b1) begin
      clk_en <= 1'b1;
      @(posedge pclk);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Register write
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask

  // Register read and compare
  task rd_is(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    `CHK({e, r}, {1'b0, exp})
  endtask

  // Ask the source model for event pulses
  task fire_ev(input logic [4:0] m);
    fire <= m;
    @(posedge pclk);
    fire <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask

  // Verdict and end of run
  task close_out;
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    close_out();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, serve} = 5'h00;
    {clk_en, paddr, pwdata, port3_level} = {1'b1, 10'h000, 32'h0, 2'b11};
    {port1_in, core_requests, ack_delay, fire, seed} = {17'h0, 16'h0010};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (reg_idx[i]) rd_is(reg_idx[i], `REG_RESET);
    apb(1'b0, 8'h01, 8'h00, v, lvl[0]);
    `CHK({lvl[0], v}, 9'h100)
    seed = lfsr(seed);
    v = seed[7:0];
    wr(`PRIO_A_IDX, 8'hFF);
    wr(`PRIO_B_IDX, v);
    rd_is(`PRIO_A_IDX, 8'h7F);
    `CHK(irq_priority, {v, 7'h7F})
    wr(`ENABLE_A_IDX, 8'h80);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      pol = {4'h0, seed[3:0]};
      lvl = {4'h0, seed[7:4]};
      en = (i == 0) ? 4'hF : seed[11:8];
      wr(`POLARITY_IDX, pol);
      port1_in <= ~pol[3:0];
      wr(`ENABLE_B_IDX, p1_exp(4'hF, 4'hF, en));
      wr(`REQ_FLAGS_IDX, 8'h00);
      port1_in <= lvl[3:0];
      repeat (2) @(posedge pclk);
      `CHK(power_down_wake, |p1_exp(pol[3:0], lvl[3:0], en))
      port1_in <= ~pol[3:0];
      rd_is(`REQ_FLAGS_IDX, p1_exp(pol[3:0], lvl[3:0], en));
      `CHK(irq_request[14:7], p1_exp(pol[3:0], lvl[3:0], en))
      wr(`REQ_FLAGS_IDX, 8'h00);
      rd_is(`REQ_FLAGS_IDX, 8'h00);
      wr(`ENABLE_B_IDX, 8'h00);
    end
    fire_ev(5'h1F);
    rd_is(`REQ_FLAGS_IDX, 8'h00);
    rd_is(`CLOCK_CTRL_IDX, 8'h80);
    rd_is(`WAKE_CTRL_IDX, 8'h40);
    wr(`ENABLE_B_IDX, 8'hE8);
    fire_ev(5'h0F);
    rd_is(`REQ_FLAGS_IDX, 8'hE8);
    `CHK(irq_request[14:7], 8'hE8)
    wr(`ENABLE_A_IDX, 8'h00);
    `CHK(irq_request, 15'h0000)
    wr(`REQ_FLAGS_IDX, 8'h00);
    wr(`REQ_FLAGS_IDX, 8'h28);
    rd_is(`REQ_FLAGS_IDX, 8'h28);
    seed = lfsr(seed);
    core_requests <= seed[3:0];
    wr(`ENABLE_A_IDX, 8'hFF);
    `CHK({irq_request[12:10], irq_request[6:3], irq_request[1]}, {3'b101, 1'b1, core_requests})
    wr(`REQ_FLAGS_IDX, 8'h00);
    for (int i = 0; i < 2; i++) begin
      ack_delay <= (i == 0) ? 4'h0 : 4'hF;
      wr(`WAKE_CTRL_IDX, 8'h83);
      while (wakeup_vector_source !== 1'b1) @(posedge pclk);
      rd_is(`WAKE_CTRL_IDX, 8'h90);
      `CHK(n_wl, i + 1)
      `CHK(n_wd, i + 1)
      `CHK(wake_run, 1'b1)
      wr(`WAKE_CTRL_IDX, 8'h80);
      `CHK(wakeup_vector_source, 1'b0)
    end
    wr(`WAKE_CTRL_IDX, 8'hCC);
    rd_is(`WAKE_CTRL_IDX, 8'h8C);
    `CHK({wake_write_value, wake_mode}, 3'b111)
    fire_ev(5'h10);
    rd_is(`WAKE_CTRL_IDX, 8'hCC);
    `CHK(wakeup_vector_source, 1'b1)
    seed = lfsr(seed);
    v = seed[7:0];
    wr(`SECONDS_IDX, v);
    wr(`CLOCK_CTRL_IDX, 8'h07);
    rd_is(`CLOCK_CTRL_IDX, 8'h04);
    `CHK({seconds_value, clock_writeback_disable}, {v, 1'b1})
    `CHK(n_cl + n_cs, 2)
    wr(`CLOCK_CTRL_IDX, 8'h78);
    fire_ev(5'h08);
    rd_is(`CLOCK_CTRL_IDX, 8'h80);
    wr(`ENABLE_A_IDX, 8'h85);
    wr(`TIMER_EXT_IDX, 8'h05);
    port3_level <= 2'b00;
    @(posedge pclk);
    rd_is(`TIMER_EXT_IDX, 8'h0F);
    `CHK({irq_request[2], irq_request[0]}, 2'b11)
    serve <= 1'b1;
    repeat (4) @(posedge pclk);
    serve <= 1'b0;
    rd_is(`TIMER_EXT_IDX, 8'h05);
    port3_level <= 2'b11;
    rd_is(`TIMER_EXT_IDX, 8'h05);
    wr(`TIMER_EXT_IDX, 8'h00);
    port3_level <= 2'b00;
    @(posedge pclk);
    rd_is(`TIMER_EXT_IDX, 8'h0A);
    close_out();
  end
endmodule

// File: inc/irq_cfg.svh
// Constants of the interrupt request flag block: register indices, bit positions, resets.
// Assumes an APB slave with 32-bit data; byte address is four times the index.
// What this block does
// R1: Port 1.2 and 1.4 flags at bits 2, 4
// R2: Bit 3 symbol flag, set by hardware/software
// R3: Bit 5 converter flag, set by hardware/software
// R4: Bit 6 watchdog flag, set by hardware/software
// R5: Bit 7 minute flag, set by hardware/software
// R6: Wake control: latch bit0, load bit1, run bit7
// R7: Wake control bit 4 is completion flag
// R8: Wake control bit 6 is wake event flag
// R9: Clock control: bit1 loads seconds, bit2 blocks writeback
// R10: Clock control bit 7 minute flag; bits 3-6 unused
// R11: Two enable banks plus global enable bit
// R12: Two priority banks; bank a top bit reads zero
// R13: Port 3 interrupts level or edge, CPU-driven
// R14: Type bit set falling edge, clear low level
// R15: Port 3 flag set on detect, cleared on vector
// R16: Wake request is OR of wake and completion
// R17: Wake flag write storage differs from read flag
// R18: Completion flag set when latch copy finishes
// R19: Enabled port 1 lines wake from power-down
// R20: Polarity register picks active level per line
// R21: Port 1 flag set only when enabled
// R22: Software clears port 1 flags itself
// R23: Port 1.0 and 1.1 flags at bits 0, 1
// R24: Software write one sets, zero clears flag
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// Register indices
`define TIMER_EXT_IDX    8'h88
`define WAKE_CTRL_IDX    8'h94
`define ENABLE_A_IDX     8'hA8
`define PRIO_A_IDX       8'hB8
`define REQ_FLAGS_IDX    8'hC0
`define CLOCK_CTRL_IDX   8'hCD
`define SECONDS_IDX      8'hCE
`define ENABLE_B_IDX     8'hE8
`define POLARITY_IDX     8'hE9
`define PRIO_B_IDX       8'hF8

// Request flag register bits
`define REQ_SYMBOL_BIT   3
`define REQ_CONV_BIT     5
`define REQ_WDOG_BIT     6
`define REQ_MINUTE_BIT   7

// Wake-up counter control bits
`define WAKE_LATCH_BIT   0
`define WAKE_LOAD_BIT    1
`define WAKE_MODE0_BIT   2
`define WAKE_MODE1_BIT   3
`define WAKE_DONE_BIT    4
`define WAKE_FLAG_BIT    6
`define WAKE_RUN_BIT     7

// Clock control bits
`define CLK_LATCH_BIT    0
`define CLK_LOAD_BIT     1
`define CLK_WBDIS_BIT    2
`define CLK_MINUTE_BIT   7

// Timer and external control bits
`define EXT_TYPE_A_BIT   0
`define EXT_REQ_A_BIT    1
`define EXT_TYPE_B_BIT   2
`define EXT_REQ_B_BIT    3

// Enable bank a global bit
`define GLOBAL_EN_BIT    7

// Reset value of every register
`define REG_RESET        8'h00

`endif

// File: inc/irq_pkg.sv
// Types of the interrupt request flag block.
// Assumes irq_cfg.svh is compiled alongside for constants.
package irq_pkg;

  // Whole block state, registered as one word
  typedef struct packed {
    logic [7:0] irq_flags;       // Extended request flags
    logic [7:0] enable_a;        // Enable bank a, bit 7 global
    logic [7:0] enable_b;        // Enable bank b
    logic [6:0] priority_a;      // Priority bank a, seven bits
    logic [7:0] priority_b;      // Priority bank b
    logic [3:0] polarity;        // Port 1 active level per line
    logic [1:0] ext_type;        // Port 3 trigger types
    logic [1:0] ext_req;         // Port 3 request flags
    logic [1:0] port3_q;         // Previous port 3 levels
    logic [1:0] wake_mode;       // Spare wake control bits
    logic       wake_run;        // Wake counter run
    logic       copy_done;       // Completion flag
    logic       copy_pending;    // Latch copy in flight
    logic       wake_flag;       // Wake event flag, read side
    logic       wake_shadow;     // Wake bit, write side
    logic       latch_strobe;    // Wake latch pulse
    logic       load_strobe;     // Wake load pulse
    logic       clk_latch;       // Clock latch pulse
    logic       clk_load;        // Seconds load pulse
    logic       clk_wb_disable;  // Writeback disable
    logic       minute_flag;     // Clock control minute flag
    logic [7:0] seconds;         // Seconds value to load
    logic [7:0] rdata;           // Read data captured at setup
  } irq_state_t;

endpackage

// File: rtl/interrupt_request_flags.sv
// Interrupt request flags, enables, priorities and wake control as an APB slave.
// Assumes synchronous event pulses and pin levels; the CPU core arbitrates requests.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "irq_cfg.svh"
module interrupt_request_flags
  import irq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic [9:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  port1_in,
  input  wire logic        symbol_event,
  input  wire logic        converter_event,
  input  wire logic        watchdog_warning,
  input  wire logic        minute_tick,
  input  wire logic        wake_event,
  input  wire logic        copy_ack,
  input  wire logic [1:0]  port3_level,
  input  wire logic        vector_taken_a,
  input  wire logic        vector_taken_b,
  input  wire logic [3:0]  core_requests,
  output logic [14:0]      irq_request,
  output logic [14:0]      irq_priority,
  output logic             power_down_wake,
  output logic             wakeup_vector_source,
  output logic             wake_latch_strobe,
  output logic             wake_load_strobe,
  output logic             wake_run,
  output logic [1:0]       wake_mode,
  output logic             wake_write_value,
  output logic             clock_latch_strobe,
  output logic             clock_load_strobe,
  output logic             clock_writeback_disable,
  output logic [7:0]       seconds_value
);

  irq_state_t s;              // Registered state
  irq_state_t next_s;         // Next state
  logic [7:0] reg_idx;        // Register index from address
  logic       addr_hit;       // Index maps to a register
  logic [7:0] rd_value;       // Read mux output
  logic       wr;             // Write takes effect this edge
  logic [3:0] p1_active;      // Port 1 lines at active level
  logic [3:0] p1_enabled;     // Enables of port 1 lines
  logic [1:0] ext_detect;     // Port 3 trigger condition
  logic [6:0] bank_a_src;     // Bank a raw sources

  // Address decode
  assign reg_idx = paddr[9:2];
  assign wr      = psel & penable & pwrite & clk_en;
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata  = {24'h000000, s.rdata};

  // Port 1 active level per line, polarity 1 means high active
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      p1_active[i] = ~(port1_in[i] ^ s.polarity[i]); // [R20]
    end
  end
  assign p1_enabled = {s.enable_b[4], s.enable_b[2:0]};

  // Enabled port 1 line at active level wakes from power-down
  assign power_down_wake = |(p1_active & p1_enabled); // [R19]

  // Port 3 trigger: falling edge when type set, low level otherwise
  assign ext_detect = (s.ext_type & s.port3_q & ~port3_level)
                    | (~s.ext_type & ~port3_level); // [R13] [R14]

  // Wake source is the level OR of both wake counter flags
  assign wakeup_vector_source = s.wake_flag | s.copy_done; // [R16]

  // Bank a order: ext a, timer 0, ext b, timer 1, uart, i2c, wake
  assign bank_a_src = {wakeup_vector_source, core_requests[3], core_requests[2],
                       core_requests[1], s.ext_req[1], core_requests[0], s.ext_req[0]};

  // Requests gated per source and by the global bit
  assign irq_request = {s.irq_flags & s.enable_b, bank_a_src & s.enable_a[6:0]}
                     & {15{s.enable_a[`GLOBAL_EN_BIT]}}; // [R11]
  assign irq_priority = {s.priority_b, s.priority_a};

  // Control outputs straight from state
  assign wake_latch_strobe       = s.latch_strobe;
  assign wake_load_strobe        = s.load_strobe;
  assign wake_run                = s.wake_run;
  assign wake_mode               = s.wake_mode;
  assign wake_write_value        = s.wake_shadow;
  assign clock_latch_strobe      = s.clk_latch;
  assign clock_load_strobe       = s.clk_load;
  assign clock_writeback_disable = s.clk_wb_disable;
  assign seconds_value           = s.seconds;

  // Read mux and decode
  always_comb begin
    addr_hit = (paddr[1:0] == 2'b00);
    rd_value = 8'h00;
    unique case (reg_idx)
      `REQ_FLAGS_IDX:  rd_value = s.irq_flags;
      `ENABLE_A_IDX:   rd_value = s.enable_a;
      `ENABLE_B_IDX:   rd_value = s.enable_b;
      `PRIO_A_IDX:     rd_value = {1'b0, s.priority_a}; // [R12]
      `PRIO_B_IDX:     rd_value = s.priority_b;
      `POLARITY_IDX:   rd_value = {4'h0, s.polarity};
      `SECONDS_IDX:    rd_value = s.seconds;
      // Strobes read as zero; wake bit returns the hardware flag
      `WAKE_CTRL_IDX:  rd_value = {s.wake_run, s.wake_flag, 1'b0, s.copy_done,
                                   s.wake_mode, 2'b00}; // [R17]
      // Bits 3 to 6 unused, read zero
      `CLOCK_CTRL_IDX: rd_value = {s.minute_flag, 4'h0, s.clk_wb_disable, 2'b00}; // [R10]
      // Timer bits live elsewhere, read zero here
      `TIMER_EXT_IDX:  rd_value = {4'h0, s.ext_req[1], s.ext_type[1],
                                   s.ext_req[0], s.ext_type[0]};
      default:         addr_hit = 1'b0;
    endcase
  end

  // Next state: software writes first, hardware sets win after
  always_comb begin
    next_s              = s;
    next_s.latch_strobe = 1'b0;
    next_s.load_strobe  = 1'b0;
    next_s.clk_latch    = 1'b0;
    next_s.clk_load     = 1'b0;
    next_s.port3_q      = port3_level;
    // Read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      next_s.rdata = addr_hit ? rd_value : 8'h00;
    end
    // Register writes
    if (wr && addr_hit) begin
      unique case (reg_idx)
        // Write one sets, write zero clears
        `REQ_FLAGS_IDX:  next_s.irq_flags = pwdata[7:0]; // [R24]
        `ENABLE_A_IDX:   next_s.enable_a = pwdata[7:0];
        `ENABLE_B_IDX:   next_s.enable_b = pwdata[7:0];
        `PRIO_A_IDX:     next_s.priority_a = pwdata[6:0]; // [R12]
        `PRIO_B_IDX:     next_s.priority_b = pwdata[7:0];
        `POLARITY_IDX:   next_s.polarity = pwdata[3:0];
        `SECONDS_IDX:    next_s.seconds = pwdata[7:0];
        `WAKE_CTRL_IDX: begin
          next_s.latch_strobe = pwdata[`WAKE_LATCH_BIT]; // [R6]
          next_s.load_strobe  = pwdata[`WAKE_LOAD_BIT];
          next_s.wake_run     = pwdata[`WAKE_RUN_BIT];
          next_s.wake_mode    = {pwdata[`WAKE_MODE1_BIT], pwdata[`WAKE_MODE0_BIT]};
          next_s.copy_done    = pwdata[`WAKE_DONE_BIT]; // [R7]
          next_s.wake_shadow  = pwdata[`WAKE_FLAG_BIT]; // [R17]
          // Writing zero clears the wake flag; writing one only fills the shadow
          if (!pwdata[`WAKE_FLAG_BIT]) begin
            next_s.wake_flag = 1'b0; // [R8]
          end
          if (pwdata[`WAKE_LATCH_BIT]) begin
            next_s.copy_pending = 1'b1;
          end
        end
        `CLOCK_CTRL_IDX: begin
          next_s.clk_latch      = pwdata[`CLK_LATCH_BIT];
          next_s.clk_load       = pwdata[`CLK_LOAD_BIT]; // [R9]
          next_s.clk_wb_disable = pwdata[`CLK_WBDIS_BIT];
          next_s.minute_flag    = pwdata[`CLK_MINUTE_BIT]; // [R10]
        end
        `TIMER_EXT_IDX: begin
          next_s.ext_type = {pwdata[`EXT_TYPE_B_BIT], pwdata[`EXT_TYPE_A_BIT]};
          next_s.ext_req  = {pwdata[`EXT_REQ_B_BIT], pwdata[`EXT_REQ_A_BIT]};
        end
        default: begin
        end
      endcase
    end
    // Port 1 flags set only on enabled lines; software clears them
    for (int i = 0; i < 4; i++) begin
      if (p1_active[i] && p1_enabled[i]) begin
        next_s.irq_flags[(i == 3) ? 4 : i] = 1'b1; // [R1] [R21] [R22] [R23]
      end
    end
    // Peripheral events, gated by their enables
    if (symbol_event && s.enable_b[`REQ_SYMBOL_BIT]) begin
      next_s.irq_flags[`REQ_SYMBOL_BIT] = 1'b1; // [R2]
    end
    if (converter_event && s.enable_b[`REQ_CONV_BIT]) begin
      next_s.irq_flags[`REQ_CONV_BIT] = 1'b1; // [R3]
    end
    if (watchdog_warning && s.enable_b[`REQ_WDOG_BIT]) begin
      next_s.irq_flags[`REQ_WDOG_BIT] = 1'b1; // [R4]
    end
    if (minute_tick && s.enable_b[`REQ_MINUTE_BIT]) begin
      next_s.irq_flags[`REQ_MINUTE_BIT] = 1'b1; // [R5]
    end
    // Clock control minute flag follows every tick
    if (minute_tick) begin
      next_s.minute_flag = 1'b1; // [R10]
    end
    // Wake counter event
    if (wake_event) begin
      next_s.wake_flag = 1'b1; // [R8]
    end
    // Copy of a previous latch finished
    if (s.copy_pending && copy_ack) begin
      next_s.copy_done    = 1'b1; // [R18]
      next_s.copy_pending = 1'b0;
    end
    // Port 3 flags: cleared on vector entry, detection wins
    if (vector_taken_a) begin
      next_s.ext_req[0] = 1'b0; // [R15]
    end
    if (vector_taken_b) begin
      next_s.ext_req[1] = 1'b0;
    end
    next_s.ext_req = next_s.ext_req | ext_detect; // [R15]
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write to wake control with the latch bit set
  sequence wake_latch_write;
    wr && addr_hit && reg_idx == `WAKE_CTRL_IDX && pwdata[`WAKE_LATCH_BIT];
  endsequence

  // Latch pulse lasts exactly one cycle
  sequence latch_pulse;
    wake_latch_strobe ##1 !wake_latch_strobe;
  endsequence

  // Read setup of priority bank a followed by its access phase
  sequence prio_a_read;
    clk_en && psel && !penable && !pwrite && reg_idx == `PRIO_A_IDX
      ##1 psel && penable;
  endsequence

  a_disabled_port1: assert property (clk_en && !s.enable_b[2] && !wr
      |=> s.irq_flags[2] == $past(s.irq_flags[2])) // [R21]
    else $error("Disabled port 1 line changed its flag");
  a_port1_set: assert property (clk_en && s.enable_b[4] && p1_active[3]
      |=> s.irq_flags[4]) // [R1] [R20]
    else $error("Active enabled port 1.4 line left flag clear");
  a_symbol_set: assert property (clk_en && symbol_event && s.enable_b[3]
      |=> s.irq_flags[3]) // [R2]
    else $error("Symbol event lost");
  a_converter_set: assert property (clk_en && converter_event && s.enable_b[5]
      |=> s.irq_flags[5]) // [R3]
    else $error("Converter event lost");
  a_watchdog_set: assert property (clk_en && watchdog_warning && s.enable_b[6]
      |=> s.irq_flags[6]) // [R4]
    else $error("Watchdog event lost");
  a_minute_set: assert property (clk_en && minute_tick
      |=> s.minute_flag && (s.irq_flags[7] == $past(s.enable_b[7]
          || ((wr && addr_hit && reg_idx == `REQ_FLAGS_IDX)
          ? pwdata[7] : s.irq_flags[7])))) // [R5] [R10]
    else $error("Minute tick not recorded");
  a_latch_strobe: assert property (wake_latch_write ##1 clk_en |-> latch_pulse) // [R6]
    else $error("Latch strobe not a single pulse");
  a_copy_done: assert property (clk_en && s.copy_pending && copy_ack
      |=> s.copy_done && !s.copy_pending) // [R18] [R7]
    else $error("Copy completion not flagged");
  a_wake_source: assert property (clk_en && wake_event
      |=> wakeup_vector_source && irq_request[6] == (s.enable_a[6] && s.enable_a[7])) // [R16] [R8]
    else $error("Wake event did not raise wake source");
  a_wake_shadow: assert property (clk_en && !s.wake_flag && !wake_event && wr
      && reg_idx == `WAKE_CTRL_IDX && pwdata[`WAKE_FLAG_BIT]
      |=> !s.wake_flag && wake_write_value) // [R17]
    else $error("Wake bit write reached the read flag");
  a_seconds_load: assert property (wr && reg_idx == `CLOCK_CTRL_IDX && pwdata[`CLK_LOAD_BIT]
      |=> clock_load_strobe && seconds_value == $past(s.seconds)) // [R9]
    else $error("Seconds load strobe missing");
  a_prio_top: assert property (prio_a_read |-> prdata[7] == 1'b0) // [R12]
    else $error("Priority bank a top bit read as one");
  a_global_gate: assert property (!s.enable_a[`GLOBAL_EN_BIT] |-> irq_request == 15'h0000) // [R11]
    else $error("Request passed with global enable off");
  a_ext_edge: assert property (clk_en && s.ext_type[0] && s.port3_q[0] && !port3_level[0]
      |=> s.ext_req[0]) // [R14] [R13]
    else $error("Falling edge on port 3 missed");
  a_ext_clear: assert property (clk_en && vector_taken_a && !ext_detect[0] && !wr
      |=> !s.ext_req[0]) // [R15]
    else $error("Port 3 flag not cleared on vector");
  a_pd_wake: assert property (s.enable_b[0] && p1_active[0] |-> power_down_wake) // [R19]
    else $error("Enabled port 1 line failed to wake");

endmodule
